// file: hw/event_timer_pkg.sv
//
// Contract
// - one shared main counter and three comparator timers numbered 0 to 2
// - non-periodic timer fires when main counter equals its comparator
// - timers 1 and 2 are 32-bit and also fire when the main counter's low 32 bits wrap
// - all three timers support one-shot non-periodic operation
// - only timer 0 has periodic mode; others are non-periodic only
// - periodic match raises interrupt if enabled, then adds last written period
// - reading timer 0 comparator in periodic mode gives next match point
// - periodic comparator sum wraps modulo comparator width through zero
// - comparator write in periodic mode becomes increment used at next match
// - global enable clear blocks all timer interrupts; setting re-allows them
// - level interrupt held until software writes one to its status bit
// - legacy routing: timer 0 drives legacy IRQ0 and advanced IRQ2, gates old timer
// - legacy routing: timer 1 drives IRQ8 both, gates clock irq; timer 2 own route
// - non-legacy: each timer uses route field; read-only capability shows valid inputs
// - counter runs in shallow idle, halts in both deeper idle states
//
package event_timer_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CAP       = 8'h00;
    localparam logic [7:0] OFS_GCFG      = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_CNT_LO    = 8'hf0;
    localparam logic [7:0] OFS_CNT_HI    = 8'hf4;
    localparam logic [7:0] OFS_T0_CFG    = 8'h80;
    localparam logic [7:0] OFS_T0_CMP_LO = 8'h84;
    localparam logic [7:0] OFS_T0_CMP_HI = 8'h88;
    localparam logic [7:0] OFS_T1_CFG    = 8'h90;
    localparam logic [7:0] OFS_T1_CMP    = 8'h94;
    localparam logic [7:0] OFS_T2_CFG    = 8'ha0;
    localparam logic [7:0] OFS_T2_CMP    = 8'ha4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GLOBAL_COUNT_ENABLE_BIT   = 0;   // global_count_enable
    localparam int LEGACY_ROUTE_ENABLE_BIT  = 1;   // legacy_route_enable
    localparam int TCFG_LVL_BIT  = 1;   // 1 = level triggered
    localparam int TCFG_IE_BIT   = 2;   // interrupt enable
    localparam int TCFG_PER_BIT  = 3;   // periodic (timer 0 only)
    localparam int TCFG_VS_BIT   = 6;   // value_set_control (timer 0 only)
    localparam int TCFG_RT_LSB   = 9;   // route select, 5 bits
    localparam int TCFG_CAP_LSB  = 16;  // route capability, 16 bits shown

    // ------------------------------------------------------------
    // widths, reset values, constants
    // ------------------------------------------------------------
    localparam int          NUM_TIMERS = 3;
    localparam int          ROUTE_W    = 5;
    localparam int          NUM_IRQ    = 32;
    localparam logic [15:0] ROUTE_CAP  = 16'hff00;  // advanced inputs 8..15 selectable
    localparam logic [4:0]  IRQ_LEG0   = 5'h00;
    localparam logic [4:0]  IRQ_ADV2   = 5'h02;
    localparam logic [4:0]  IRQ_RTC8   = 5'h08;
    localparam logic [31:0] CAP_ID     = 32'h0000_0a5a;  // arbitrary identity value
    localparam logic [63:0] CMP_RESET  = 64'hffff_ffff_ffff_ffff;
    localparam logic [31:0] CMP32_RESET = 32'hffff_ffff;

    // ------------------------------------------------------------
    // idle states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDLE_RUN     = 2'b00,
        IDLE_SHALLOW = 2'b01,
        IDLE_DEEP_A  = 2'b11,
        IDLE_DEEP_B  = 2'b10
    } idle_state_e;

    // comparator match test, shared by all three timers
    function automatic logic cmp_hit(input logic [63:0] cnt, input logic [63:0] cmp);
        cmp_hit = (cnt == cmp);
    endfunction : cmp_hit

endpackage : event_timer_pkg

// file: hw/timer_irq_slice.sv
`timescale 1ns/1ns
// one comparator timer's status flag; set wins over a software clear
module timer_irq_slice
    import event_timer_pkg::*;
(
    input  wire logic clk,        // timer clock
    input  wire logic srst,       // synchronous reset
    input  wire logic fire,       // one-cycle timer event
    input  wire logic irq_en,     // per-timer interrupt enable
    input  wire logic glb_en,     // global_count_enable
    input  wire logic level_mode, // level triggered when high
    input  wire logic clr,        // software writes one to status bit
    output logic      sts,        // sticky status bit
    output logic      irq_line    // interrupt towards router
);
    logic sts_q;
    logic pulse_q;
    wire  evt = fire & irq_en & glb_en;

    // ------------------------------------------------------------
    // status and pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sts_q   <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            sts_q   <= evt | (sts_q & ~clr);
            pulse_q <= evt;
        end
    end

    assign sts = sts_q;
    // level held until cleared; edge mode needs no clearing
    assign irq_line = level_mode ? (sts_q & glb_en) : pulse_q;
endmodule : timer_irq_slice

// file: hw/event_timer_block.sv
`timescale 1ns/1ns
// event timer: main counter, three comparators, avalon-mm slave
module event_timer_block
    import event_timer_pkg::*;
(
    input  wire logic        clk,              // 25 MHz timer clock
    input  wire logic        srst,             // sync reset, active high
    input  wire logic [7:0]  avs_address,      // byte address
    input  wire logic        avs_read,         // read strobe
    input  wire logic        avs_write,        // write strobe
    input  wire logic [31:0] avs_writedata,    // write data
    input  wire logic [3:0]  avs_byteenable,   // byte lanes
    output logic      [31:0] avs_readdata,     // read data
    output logic             avs_waitrequest,  // stall
    input  wire logic [1:0]  idle_state,       // platform idle state pins
    output logic      [NUM_IRQ-1:0] adv_irq,   // advanced controller inputs
    output logic             legacy_irq0,      // legacy controller irq0
    output logic             legacy_irq8,      // legacy controller irq8
    output logic             pit_irq_gate_n,   // low suppresses old interval timer
    output logic             rtc_irq_gate_n    // low suppresses clock irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [63:0] cnt_q;
    logic [63:0] cmp0_q;
    logic [63:0] per0_q;
    logic [31:0] cmp1_q;
    logic [31:0] cmp2_q;
    logic        en_q;
    logic        lre_q;
    logic [TCFG_RT_LSB+ROUTE_W-1:0] cfg_q [NUM_TIMERS];
    logic        vs_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [1:0]  idle_s1_q;
    logic [1:0]  idle_s2_q;
    logic [NUM_IRQ-1:0] adv_q;
    logic        leg0_q;
    logic        leg8_q;
    logic        pitg_q;
    logic        rtcg_q;

    // ------------------------------------------------------------
    // bus decode: one wait cycle, answer on the second edge
    // ------------------------------------------------------------
    wire        req    = (avs_read | avs_write) & ~ack_q;
    wire        wr     = avs_write & ack_q;   // lands at the answer edge
    wire [31:0] wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        wr_gc  = wr & (avs_address == OFS_GCFG);
    wire        wr_st  = wr & (avs_address == OFS_STATUS);
    wire        wr_clo = wr & (avs_address == OFS_CNT_LO);
    wire        wr_chi = wr & (avs_address == OFS_CNT_HI);
    wire        wr_c0  = wr & (avs_address == OFS_T0_CFG);
    wire        wr_c1  = wr & (avs_address == OFS_T1_CFG);
    wire        wr_c2  = wr & (avs_address == OFS_T2_CFG);
    wire        wr_m0l = wr & (avs_address == OFS_T0_CMP_LO);
    wire        wr_m0h = wr & (avs_address == OFS_T0_CMP_HI);
    wire        wr_m1  = wr & (avs_address == OFS_T1_CMP);
    wire        wr_m2  = wr & (avs_address == OFS_T2_CMP);
    wire [31:0] wdat   = avs_writedata & wmask;

    // ------------------------------------------------------------
    // idle state synchroniser and halt
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            idle_s1_q <= 2'b00;
            idle_s2_q <= 2'b00;
        end
        else
        begin
            idle_s1_q <= idle_state;
            idle_s2_q <= idle_s1_q;
        end
    end

    // shallow idle keeps running; both deep states stop the count
    wire halted = (idle_s2_q == IDLE_DEEP_A) | (idle_s2_q == IDLE_DEEP_B);
    wire run    = en_q & ~halted;

    // ------------------------------------------------------------
    // main counter and wrap detect
    // ------------------------------------------------------------
    wire [63:0] cnt_inc = cnt_q + 64'h1;
    // timers 1 and 2 see the low word; its wrap is a second event
    wire        wrap32  = run & (cnt_q[31:0] == 32'hffff_ffff);

    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_q <= 64'h0;
        else if (wr_clo)
            cnt_q <= {cnt_q[63:32], (cnt_q[31:0] & ~wmask) | wdat};
        else if (wr_chi)
            cnt_q <= {(cnt_q[63:32] & ~wmask) | wdat, cnt_q[31:0]};
        else if (run)
            cnt_q <= cnt_inc;
    end

    // ------------------------------------------------------------
    // comparator matches: only on a counting tick, so one per value
    // ------------------------------------------------------------
    wire per0   = cfg_q[0][TCFG_PER_BIT];
    wire hit0   = run & cmp_hit(cnt_q, cmp0_q);
    wire hit1   = run & cmp_hit({32'h0, cnt_q[31:0]}, {32'h0, cmp1_q});
    wire hit2   = run & cmp_hit({32'h0, cnt_q[31:0]}, {32'h0, cmp2_q});
    wire [2:0] fire = {hit2 | wrap32, hit1 | wrap32, hit0};
    // periodic sum wraps in 64 bits, passing through zero
    wire [63:0] cmp0_next = cmp0_q + per0_q;

    // ------------------------------------------------------------
    // timer 0 comparator: direct load, period latch, auto advance
    // ------------------------------------------------------------
    wire        ld0   = wr_m0l | wr_m0h;
    wire [63:0] cmp0_w = wr_m0l ? {cmp0_q[63:32], (cmp0_q[31:0] & ~wmask) | wdat}
                                : {(cmp0_q[63:32] & ~wmask) | wdat, cmp0_q[31:0]};
    wire [63:0] per0_w = wr_m0l ? {per0_q[63:32], (per0_q[31:0] & ~wmask) | wdat}
                                : {(per0_q[63:32] & ~wmask) | wdat, per0_q[31:0]};
    // non-periodic or value-set: write goes straight to the comparator
    wire direct0 = vs_q | ~per0;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmp0_q <= CMP_RESET;
            per0_q <= 64'h0;
        end
        else if (ld0)
        begin
            per0_q <= per0_w;
            if (direct0)
                cmp0_q <= cmp0_w;
            else if (hit0)
                cmp0_q <= cmp0_q + per0_w;
        end
        else if (hit0 & per0)
            cmp0_q <= cmp0_next;
    end

    // value-set bit clears after one comparator write
    always_ff @(posedge clk)
    begin
        if (srst)
            vs_q <= 1'b0;
        else if (wr_c0 & avs_byteenable[0] & avs_writedata[TCFG_VS_BIT])
            vs_q <= 1'b1;
        else if (ld0)
            vs_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // timers 1 and 2 comparators and configs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmp1_q <= CMP32_RESET;
            cmp2_q <= CMP32_RESET;
        end
        else
        begin
            if (wr_m1)
                cmp1_q <= (cmp1_q & ~wmask) | wdat;
            if (wr_m2)
                cmp2_q <= (cmp2_q & ~wmask) | wdat;
        end
    end

    // periodic bit kept only for timer 0; value-set never stored here
    wire [TCFG_RT_LSB+ROUTE_W-1:0] cfg_mask0 = 14'h3e0e;
    wire [TCFG_RT_LSB+ROUTE_W-1:0] cfg_mask12 = 14'h3e06;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
            cfg_q[2] <= '0;
        end
        else
        begin
            if (wr_c0)
                cfg_q[0] <= avs_writedata[13:0] & cfg_mask0;
            if (wr_c1)
                cfg_q[1] <= avs_writedata[13:0] & cfg_mask12;
            if (wr_c2)
                cfg_q[2] <= avs_writedata[13:0] & cfg_mask12;
        end
    end

    // ------------------------------------------------------------
    // global config
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            en_q  <= 1'b0;
            lre_q <= 1'b0;
        end
        else if (wr_gc & avs_byteenable[0])
        begin
            en_q  <= avs_writedata[GLOBAL_COUNT_ENABLE_BIT];
            lre_q <= avs_writedata[LEGACY_ROUTE_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // per-timer status and interrupt lines
    // ------------------------------------------------------------
    logic [NUM_TIMERS-1:0] sts;
    logic [NUM_TIMERS-1:0] tirq;

    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++)
        begin : g_tmr
            timer_irq_slice u_slice (
                .clk        (clk),
                .srst       (srst),
                .fire       (fire[g]),
                .irq_en     (cfg_q[g][TCFG_IE_BIT]),
                .glb_en     (en_q),
                .level_mode (cfg_q[g][TCFG_LVL_BIT]),
                .clr        (wr_st & avs_byteenable[0] & avs_writedata[g]),
                .sts        (sts[g]),
                .irq_line   (tirq[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // routing: legacy fixes timers 0 and 1, timer 2 always uses its field
    // ------------------------------------------------------------
    wire [ROUTE_W-1:0] rt0 = cfg_q[0][TCFG_RT_LSB +: ROUTE_W];
    wire [ROUTE_W-1:0] rt1 = cfg_q[1][TCFG_RT_LSB +: ROUTE_W];
    wire [ROUTE_W-1:0] rt2 = cfg_q[2][TCFG_RT_LSB +: ROUTE_W];
    wire [ROUTE_W-1:0] dst0 = lre_q ? IRQ_ADV2 : rt0;
    wire [ROUTE_W-1:0] dst1 = lre_q ? IRQ_RTC8 : rt1;
    wire [ROUTE_W-1:0] dst2 = rt2;

    logic [NUM_IRQ-1:0] adv_d;
    always_comb
    begin
        adv_d = '0;
        adv_d[dst0] = adv_d[dst0] | tirq[0];
        adv_d[dst1] = adv_d[dst1] | tirq[1];
        adv_d[dst2] = adv_d[dst2] | tirq[2];
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] tcfg0_rd = {ROUTE_CAP, 16'(cfg_q[0])} | (32'(vs_q) << TCFG_VS_BIT);
    wire [31:0] rd_mux =
        (avs_address == OFS_CAP)       ? CAP_ID :
        (avs_address == OFS_GCFG)      ? {30'h0, lre_q, en_q} :
        (avs_address == OFS_STATUS)    ? {29'h0, sts} :
        (avs_address == OFS_CNT_LO)    ? cnt_q[31:0] :
        (avs_address == OFS_CNT_HI)    ? cnt_q[63:32] :
        (avs_address == OFS_T0_CFG)    ? tcfg0_rd :
        (avs_address == OFS_T0_CMP_LO) ? cmp0_q[31:0] :
        (avs_address == OFS_T0_CMP_HI) ? cmp0_q[63:32] :
        (avs_address == OFS_T1_CFG)    ? {ROUTE_CAP, 16'(cfg_q[1])} :
        (avs_address == OFS_T1_CMP)    ? cmp1_q :
        (avs_address == OFS_T2_CFG)    ? {ROUTE_CAP, 16'(cfg_q[2])} :
        (avs_address == OFS_T2_CMP)    ? cmp2_q : 32'h0;   // unmapped reads zero

    // ------------------------------------------------------------
    // bus answer and registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
            adv_q   <= '0;
            leg0_q  <= 1'b0;
            leg8_q  <= 1'b0;
            pitg_q  <= 1'b1;
            rtcg_q  <= 1'b1;
        end
        else
        begin
            ack_q   <= req;
            rdata_q <= rd_mux;
            adv_q   <= adv_d;
            leg0_q  <= lre_q & tirq[0];
            leg8_q  <= lre_q & tirq[1];
            pitg_q  <= ~lre_q;
            rtcg_q  <= ~lre_q;
        end
    end

    // waitrequest low only in the answer cycle
    assign avs_waitrequest = ~ack_q;
    assign avs_readdata    = rdata_q;
    assign adv_irq         = adv_q;
    assign legacy_irq0     = leg0_q;
    assign legacy_irq8     = leg8_q;
    assign pit_irq_gate_n  = pitg_q;
    assign rtc_irq_gate_n  = rtcg_q;
endmodule : event_timer_block

// file: bench/event_timer_sva.sv
`timescale 1ns/1ns
// ----------------------------------
// port checker
// ----------------------------------
module event_timer_sva
    import event_timer_pkg::*;
(
    input wire logic               clk,             // clock
    input wire logic               srst,            // reset
    input wire logic [7:0]         avs_address,     // address
    input wire logic               avs_read,        // read
    input wire logic               avs_write,       // write
    input wire logic [31:0]        avs_writedata,   // wdata
    input wire logic [3:0]         avs_byteenable,  // lanes
    input wire logic [31:0]        avs_readdata,    // rdata
    input wire logic               avs_waitrequest, // stall
    input wire logic [1:0]         idle_state,      // idle pins
    input wire logic [NUM_IRQ-1:0] adv_irq,         // adv irqs
    input wire logic               legacy_irq0,     // irq0
    input wire logic               legacy_irq8,     // irq8
    input wire logic               pit_irq_gate_n,  // timer gate
    input wire logic               rtc_irq_gate_n   // clock gate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // shadow of the global config, written on the answer edge only
    wire  take_w = (avs_read || avs_write) && avs_waitrequest;
    wire  gcfg_w = !avs_waitrequest && avs_write && avs_address == OFS_GCFG && avs_byteenable[0];
    logic en_q;
    logic lre_q;
    always_ff @(posedge clk)
    begin
        en_q  <= srst ? 1'b0 : (gcfg_w ? avs_writedata[GLOBAL_COUNT_ENABLE_BIT] : en_q);
        lre_q <= srst ? 1'b0 : (gcfg_w ? avs_writedata[LEGACY_ROUTE_ENABLE_BIT] : lre_q);
    end

    // settled routing, gated counter
    sequence s_lre_still;
        $stable(lre_q) [*3];
    endsequence
    sequence s_en_off;
        !en_q [*4];
    endsequence

    property p_bus_answer;
        take_w |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("late bus answer");
    property p_bus_once;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_bus_once: assert property (p_bus_once) else $error("answer held too long");
    property p_unmapped;
        take_w && avs_read && avs_address == 8'h3c |=> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pit_gate;
        s_lre_still |-> pit_irq_gate_n == !lre_q;
    endproperty
    a_pit_gate: assert property (p_pit_gate) else $error("timer gate wrong");
    property p_rtc_gate;
        s_lre_still |-> rtc_irq_gate_n == !lre_q;
    endproperty
    a_rtc_gate: assert property (p_rtc_gate) else $error("clock gate wrong");
    property p_irq0_pair;
        s_lre_still ##0 lre_q |-> legacy_irq0 == adv_irq[2];
    endproperty
    a_irq0_pair: assert property (p_irq0_pair) else $error("irq0 pair split");
    property p_irq8_pair;
        s_lre_still ##0 lre_q |-> legacy_irq8 == adv_irq[8];
    endproperty
    a_irq8_pair: assert property (p_irq8_pair) else $error("irq8 pair split");
    property p_no_legacy;
        s_lre_still ##0 !lre_q |-> !legacy_irq0 && !legacy_irq8;
    endproperty
    a_no_legacy: assert property (p_no_legacy) else $error("legacy irq active");
    property p_en_off;
        s_en_off |-> (adv_irq & ~$past(adv_irq)) == '0 && !$rose(legacy_irq0)
            && !$rose(legacy_irq8);
    endproperty
    a_en_off: assert property (p_en_off) else $error("irq while disabled");
endmodule : event_timer_sva

// file: bench/irq_sink.sv
`timescale 1ns/1ns
// ----------------------------------
// controller side: counts requests
// ----------------------------------
module irq_sink
(
    input  wire logic        clk,          // clock
    input  wire logic        srst,         // reset
    input  wire logic [33:0] lines,        // adv, irq0, irq8
    output logic      [7:0]  n_rise [0:33] // edges per line
);
    logic [33:0] prev_q;

    // one count per rising edge; a shared edge line would merge two sources
    always_ff @(posedge clk)
    begin
        prev_q <= srst ? 34'h0 : lines;
        for (int i = 0; i < 34; i++)
            n_rise[i] <= srst ? 8'h00 : n_rise[i] + 8'(lines[i] && !prev_q[i]);
    end
endmodule : irq_sink

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import event_timer_pkg::*;
    localparam logic [31:0] IE = 32'h1 << TCFG_IE_BIT;
    localparam logic [31:0] LV = 32'h1 << TCFG_LVL_BIT;
    localparam logic [31:0] PER = 32'h1 << TCFG_PER_BIT;
    localparam logic [31:0] VS = 32'h1 << TCFG_VS_BIT;
    localparam idle_state_e IDL [4] = '{IDLE_RUN, IDLE_SHALLOW, IDLE_DEEP_A, IDLE_DEEP_B};
    localparam logic [31:0] STEP [4] = '{32'd3, 32'd3, 32'd0, 32'd0};
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, rd, c0, lf = 32'he6953771;
    logic [3:0] avs_byteenable = 4'hf;
    logic [1:0] idle_state = 2'b00;
    logic [31:0] avs_readdata, exp_q [$], msk_q [$];
    logic avs_waitrequest, legacy_irq0, legacy_irq8, pit_irq_gate_n, rtc_irq_gate_n;
    logic [NUM_IRQ-1:0] adv_irq;
    logic [7:0] n_rise [0:33], s0, s1, s2, s3;
    int n_fail = 0, n_tests = 0;

    event_timer_block event_timer_block_i (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .idle_state(idle_state), .adv_irq(adv_irq),
        .legacy_irq0(legacy_irq0), .legacy_irq8(legacy_irq8),
        .pit_irq_gate_n(pit_irq_gate_n), .rtc_irq_gate_n(rtc_irq_gate_n));
    irq_sink irq_sink_i (.clk(clk), .srst(srst),
        .lines({legacy_irq8, legacy_irq0, adv_irq}), .n_rise(n_rise));

    initial
        forever #20 clk = ~clk;

    // ----------------------------------
    // tasks
    // ----------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [31:0] rt(input int r);
        rt = 32'(r) << TCFG_RT_LSB;
    endfunction : rt
    // request held until waitrequest is sampled low, bounded wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50)
        begin
            n_fail++;
            stop_test();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rdc
    task automatic arm(input int t, input logic [31:0] c, input logic [31:0] f);
        logic [7:0] b;
        b = 8'h80 + 8'(t * 16);
        if (t == 0) wr(b, f | VS);
        wr(b + 8'h04, c);
        if (t == 0) wr(b, f | VS);
        if (t == 0) wr(OFS_T0_CMP_HI, 32'h0);
        wr(b, f);
    endtask : arm
    task automatic restart;
        wr(OFS_GCFG, 32'h0);
        wr(OFS_CNT_LO, 32'h0);
        wr(OFS_CNT_HI, 32'h0);
    endtask : restart

    // read results are checked against the oldest note
    always @(posedge clk)
        if (avs_read && !avs_waitrequest && exp_q.size() > 0)
        begin
            if (msk_q[0] != 32'h0)
                chk("readdata", exp_q[0], avs_readdata & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end

    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdc(OFS_GCFG, 32'h0, 32'hffffffff);
        rdc(OFS_T1_CMP, CMP32_RESET, 32'hffffffff);
        wr(OFS_T2_CFG, 32'h00ff0000);
        rdc(OFS_T2_CFG, {ROUTE_CAP, 16'h0}, 32'hffff0000);
        rdc(8'h3c, 32'h0, 32'hffffffff);
        repeat (3)
        begin
            lf = lfsr(lf);
            wr(OFS_T2_CMP, lf);
            rdc(OFS_T2_CMP, lf, 32'hffffffff);
        end
        wr(OFS_GCFG, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            idle_state <= IDL[i];
            repeat (4) @(posedge clk);
            rdc(OFS_CNT_LO, 32'h0, 32'h0);
            c0 = rd;
            rdc(OFS_CNT_LO, 32'h0, 32'h0);
            chk("count step", STEP[i], rd - c0);
        end
        idle_state <= IDLE_RUN;
        $display("test registers and counter done");
        restart();
        for (int t = 0; t < 3; t++)
            arm(t, 32'(40 + 10 * t), rt(8 + t) | IE);
        wr(OFS_GCFG, 32'h1);
        repeat (100) @(posedge clk);
        for (int t = 0; t < 3; t++)
            chk("one shot", 32'h1, 32'(n_rise[8 + t]));
        wr(OFS_GCFG, 32'h0);
        wr(OFS_CNT_LO, 32'hfffffff0);
        wr(OFS_GCFG, 32'h1);
        repeat (40) @(posedge clk);
        chk("wrap t0", 32'h1, 32'(n_rise[8]));
        chk("wrap t1", 32'h2, 32'(n_rise[9]));
        chk("wrap t2", 32'h2, 32'(n_rise[10]));
        $display("test one shot done");
        restart();
        arm(1, 32'h8, rt(9) | IE | LV);
        wr(OFS_GCFG, 32'h1);
        repeat (30) @(posedge clk);
        chk("level held", 32'h1, 32'(adv_irq[9]));
        rdc(OFS_STATUS, 32'h2, 32'h2);
        wr(OFS_STATUS, 32'h2);
        repeat (3) @(posedge clk);
        chk("level cleared", 32'h0, 32'(adv_irq[9]));
        restart();
        s0 = n_rise[8];
        arm(0, 32'h20, rt(8) | IE | PER);
        wr(OFS_GCFG, 32'h1);
        repeat (40) @(posedge clk);
        rdc(OFS_T0_CMP_LO, 32'h40, 32'hffffffff);
        wr(OFS_T0_CMP_LO, 32'h10);
        repeat (20) @(posedge clk);
        rdc(OFS_T0_CMP_LO, 32'h50, 32'hffffffff);
        repeat (4) @(posedge clk);
        chk("periodic", 32'h2, 32'(n_rise[8] - s0));
        $display("test level and periodic done");
        restart();
        arm(0, 32'd20, IE);
        arm(1, 32'd30, IE);
        s0 = n_rise[32];
        s1 = n_rise[33];
        s2 = n_rise[2];
        s3 = n_rise[8];
        wr(OFS_GCFG, 32'h3);
        repeat (45) @(posedge clk);
        chk("legacy irq0", 32'h1, 32'(n_rise[32] - s0));
        chk("legacy irq8", 32'h1, 32'(n_rise[33] - s1));
        chk("adv irq2", 32'h1, 32'(n_rise[2] - s2));
        chk("adv irq8", 32'h1, 32'(n_rise[8] - s3));
        chk("timer gate", 32'h0, 32'(pit_irq_gate_n));
        chk("clock gate", 32'h0, 32'(rtc_irq_gate_n));
        wr(OFS_GCFG, 32'h0);
        $display("test legacy routing done");
        stop_test();
    end
endmodule : testbench

bind event_timer_block event_timer_sva event_timer_sva_i (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_state(idle_state), .adv_irq(adv_irq), .legacy_irq0(legacy_irq0),
    .legacy_irq8(legacy_irq8), .pit_irq_gate_n(pit_irq_gate_n),
    .rtc_irq_gate_n(rtc_irq_gate_n));
